// >>> flash_host_pkg.sv
// Purpose : Shared constants, timing counts and encodings for the flash host controller
// Assumes : 100 MHz system clock; status bits sit at fixed positions of the data bus
// Notes   : All timing figures are kept in their own unit; cycle counts derive from them
`default_nettype none
package flash_host_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ              = 100;
  localparam int T_RESET_BUSY_NS      = 20000; // Reset low to read mode, algorithm running
  localparam int T_RESET_IDLE_NS      = 500;   // Reset low to read mode, device idle
  localparam int T_RESET_RECOVER_NS   = 50;    // Reset high before the first read
  localparam int T_UNPROTECT_SETUP_NS = 4000;  // Elevated reset before the first write
  localparam int T_UNPROTECT_HOLD_NS  = 4000;  // Elevated reset after ready goes high
  localparam int T_READ_CYCLE_NS      = 85;    // Slowest speed grade read cycle
  localparam int T_OE_HIGH_NS         = 20;    // Output enable high between polls
  localparam int T_WRITE_PULSE_NS     = 35;    // Write enable low width
  localparam int T_WRITE_HIGH_NS      = 30;    // Write enable high width

  // Least times round up and never drop below one cycle
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    if (c < 1) begin
      c = 1;
    end
    return c;
  endfunction

  localparam int CYC_RESET_BUSY      = ns_to_cycles(T_RESET_BUSY_NS);
  localparam int CYC_RESET_IDLE      = ns_to_cycles(T_RESET_IDLE_NS);
  localparam int CYC_RESET_RECOVER   = ns_to_cycles(T_RESET_RECOVER_NS);
  localparam int CYC_UNPROTECT_SETUP = ns_to_cycles(T_UNPROTECT_SETUP_NS);
  localparam int CYC_UNPROTECT_HOLD  = ns_to_cycles(T_UNPROTECT_HOLD_NS);
  localparam int CYC_READ_CYCLE      = ns_to_cycles(T_READ_CYCLE_NS);
  localparam int CYC_OE_HIGH         = ns_to_cycles(T_OE_HIGH_NS);
  localparam int CYC_WRITE_PULSE     = ns_to_cycles(T_WRITE_PULSE_NS);
  localparam int CYC_WRITE_HIGH      = ns_to_cycles(T_WRITE_HIGH_NS);

  localparam int TIMER_W = 12;

  // ---------------------------------------------------------------------------
  // Status bit positions
  // ---------------------------------------------------------------------------
  localparam int ERASE_SUSPEND_BIT_POS = 2;
  localparam int TOGGLE_BIT_POS        = 6;
  localparam int DATA_POLL_BIT_POS     = 7;

  // ---------------------------------------------------------------------------
  // Commands and states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_RESET           = 3'h0,
    OP_READ            = 3'h1,
    OP_WRITE           = 3'h2,
    OP_POLL            = 3'h3,
    OP_UNPROTECT_ENTER = 3'h4,
    OP_UNPROTECT_EXIT  = 3'h5
  } host_op_e;

  typedef enum logic [3:0] {
    ST_IDLE       = 4'h0,
    ST_RST_LOW    = 4'h1,
    ST_RST_REC    = 4'h2,
    ST_RD_ACT     = 4'h3,
    ST_RD_GAP     = 4'h4,
    ST_WR_ACT     = 4'h5,
    ST_WR_HIGH    = 4'h6,
    ST_POLL_ACT   = 4'h7,
    ST_POLL_GAP   = 4'h8,
    ST_UNP_SETUP  = 4'h9,
    ST_UNP_WAIT   = 4'hA,
    ST_UNP_HOLD   = 4'hB
  } host_state_e;

endpackage
`default_nettype wire

// >>> flash_host_timer.sv
// Purpose : Down-counting wait timer for the flash host sequencer
// Assumes : load is a one-cycle pulse; value is at least one
// Notes   : busy covers the load cycle so a waiting state never sees a stale zero
`timescale 1ns/10ps
`default_nettype none
module flash_host_timer
  import flash_host_pkg::*;
#(
  parameter int WIDTH = flash_host_pkg::TIMER_W
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] value,
  // Status
  output logic                  busy
);

  logic [WIDTH-1:0] count;

  // A counter without bits cannot hold any wait
  if (WIDTH < 1) begin : g_bad_width
    $error("flash_host_timer: width must be at least one bit");
  end

  // ---------------------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------------------
  // Loads on the pulse, then counts down to zero and rests there
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (load) begin
      count <= value;
    end else if (count != '0) begin
      count <= count - WIDTH'(1);
    end
  end

  assign busy = load | (count != '0);

endmodule
`default_nettype wire

// >>> flash_host_ctrl.sv
// Purpose : Host sequencer for an asynchronous parallel flash: reset, read, write,
//           toggle-bit polling and temporary sector unprotect entry and exit
// Assumes : All flash pins are synchronous to clk; one command at a time
// Notes   : Timing uses the slowest speed grade so any part of the family is served
//
// Functional notes
// - Host waits at least 50 ns after reset release before reading.
// - Status reads are delimited by cycling output enable or chip enable.
// - After an erase, host polls status at an address inside the region.
// - Host holds reset elevated 4 us before the first unprotected write.
// - Host keeps reset elevated 4 us after ready returns high.
`timescale 1ns/10ps
`default_nettype none
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int ADDR_W     = 21,
  parameter int DATA_W     = 16,
  parameter int POLL_LIMIT = 65535,
  parameter bit WORD_MODE  = 1'b1
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // User command port
  input  wire logic              cmd_valid,
  input  wire flash_host_pkg::host_op_e cmd_op,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_data,
  output logic                   cmd_ready,
  // User response port
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data,
  output logic                   rsp_timeout,
  output logic                   in_unprotect,
  // Flash pins
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [DATA_W-1:0]      flash_dq_out,
  output logic                   flash_dq_oe_n,
  input  wire logic [DATA_W-1:0] flash_dq_in,
  output logic                   flash_reset_n,
  output logic                   unprotect_high_voltage,
  output logic                   flash_width_select,
  input  wire logic              ready_busy_n
);

  import flash_host_pkg::*;

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  if (DATA_W < 8 || ADDR_W < 1) begin : g_bad_width
    $error("flash_host_ctrl: data bus must hold the status bits");
  end
  if (CYC_RESET_BUSY >= (1 << TIMER_W) || POLL_LIMIT < 2 || POLL_LIMIT > 65535) begin : g_bad_cnt
    $error("flash_host_ctrl: timer or poll limit out of range");
  end

  // ---------------------------------------------------------------------------
  // State and timer
  // ---------------------------------------------------------------------------
  host_state_e        state;
  logic               tmr_load;
  logic [TIMER_W-1:0] tmr_value;
  logic               tmr_busy;
  logic               prev_toggle;
  logic               have_prev;
  logic [15:0]        poll_count;
  logic [DATA_W-1:0]  poll_data;
  logic               older_toggle;
  logic               last_equal;

  flash_host_timer #(
    .WIDTH (TIMER_W)
  ) u_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .load    (tmr_load),
    .value   (tmr_value),
    .busy    (tmr_busy)
  );

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  // One process owns every pin so that edges on the bus follow states exactly
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state                  <= ST_IDLE;
      tmr_load               <= 1'b0;
      tmr_value              <= '0;
      cmd_ready              <= 1'b0;
      rsp_valid              <= 1'b0;
      rsp_data               <= '0;
      rsp_timeout            <= 1'b0;
      in_unprotect           <= 1'b0;
      flash_ce_n             <= 1'b1;
      flash_oe_n             <= 1'b1;
      flash_we_n             <= 1'b1;
      flash_addr             <= '0;
      flash_dq_out           <= '0;
      flash_dq_oe_n          <= 1'b1;
      flash_reset_n          <= 1'b1;
      unprotect_high_voltage <= 1'b0;
      flash_width_select     <= 1'b0;
      prev_toggle            <= 1'b0;
      have_prev              <= 1'b0;
      poll_count             <= '0;
      poll_data              <= '0;
    end else begin
      tmr_load           <= 1'b0;
      rsp_valid          <= 1'b0;
      flash_width_select <= WORD_MODE;
      case (state)
        ST_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready   <= 1'b0;
            rsp_timeout <= 1'b0;
            flash_addr  <= cmd_addr;
            tmr_load    <= 1'b1;
            case (cmd_op)
              OP_RESET: begin
                // A running algorithm needs the long abort window
                flash_reset_n <= 1'b0;
                tmr_value     <= ready_busy_n ? TIMER_W'(CYC_RESET_IDLE)
                                              : TIMER_W'(CYC_RESET_BUSY);
                state         <= ST_RST_LOW;
              end
              OP_READ: begin
                flash_ce_n <= 1'b0;
                flash_oe_n <= 1'b0;
                tmr_value  <= TIMER_W'(CYC_READ_CYCLE);
                state      <= ST_RD_ACT;
              end
              OP_WRITE: begin
                flash_ce_n    <= 1'b0;
                flash_we_n    <= 1'b0;
                flash_dq_out  <= cmd_data;
                flash_dq_oe_n <= 1'b0;
                tmr_value     <= TIMER_W'(CYC_WRITE_PULSE);
                state         <= ST_WR_ACT;
              end
              OP_POLL: begin
                // Caller supplies an address inside the erased region
                flash_ce_n <= 1'b0;
                flash_oe_n <= 1'b0;
                have_prev  <= 1'b0;
                poll_count <= '0;
                tmr_value  <= TIMER_W'(CYC_READ_CYCLE);
                state      <= ST_POLL_ACT;
              end
              OP_UNPROTECT_ENTER: begin
                unprotect_high_voltage <= 1'b1;
                tmr_value              <= TIMER_W'(CYC_UNPROTECT_SETUP);
                state                  <= ST_UNP_SETUP;
              end
              default: begin
                tmr_load <= 1'b0;
                state    <= ST_UNP_WAIT;
              end
            endcase
          end
        end
        ST_RST_LOW: begin
          if (!tmr_busy) begin
            flash_reset_n <= 1'b1;
            tmr_load      <= 1'b1;
            tmr_value     <= TIMER_W'(CYC_RESET_RECOVER);
            state         <= ST_RST_REC;
          end
        end
        ST_RST_REC: begin
          // No read is started until the recovery time has run out
          if (!tmr_busy) begin
            rsp_valid <= 1'b1;
            state     <= ST_IDLE;
          end
        end
        ST_RD_ACT: begin
          if (!tmr_busy) begin
            rsp_data   <= flash_dq_in;
            rsp_valid  <= 1'b1;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            tmr_load   <= 1'b1;
            tmr_value  <= TIMER_W'(CYC_OE_HIGH);
            state      <= ST_RD_GAP;
          end
        end
        ST_RD_GAP, ST_WR_HIGH: begin
          if (!tmr_busy) begin
            if (state == ST_WR_HIGH) begin
              rsp_valid <= 1'b1;
            end
            state <= ST_IDLE;
          end
        end
        ST_WR_ACT: begin
          if (!tmr_busy) begin
            flash_ce_n    <= 1'b1;
            flash_we_n    <= 1'b1;
            flash_dq_oe_n <= 1'b1;
            tmr_load      <= 1'b1;
            tmr_value     <= TIMER_W'(CYC_WRITE_HIGH);
            state         <= ST_WR_HIGH;
          end
        end
        ST_POLL_ACT: begin
          if (!tmr_busy) begin
            // Output enable goes high to mark the end of each status read
            flash_oe_n  <= 1'b1;
            poll_data   <= flash_dq_in;
            prev_toggle <= flash_dq_in[TOGGLE_BIT_POS];
            have_prev   <= 1'b1;
            poll_count  <= poll_count + 16'h0001;
            tmr_load    <= 1'b1;
            tmr_value   <= TIMER_W'(CYC_OE_HIGH);
            state       <= ST_POLL_GAP;
          end
        end
        ST_POLL_GAP: begin
          if (!tmr_busy) begin
            // Two reads in a row with the same toggle bit mean the algorithm ended
            if (have_prev && poll_count > 16'h0001 &&
                prev_toggle == poll_data[TOGGLE_BIT_POS] && last_equal) begin
              flash_ce_n <= 1'b1;
              rsp_data   <= poll_data;
              rsp_valid  <= 1'b1;
              state      <= ST_IDLE;
            end else if (poll_count >= 16'(POLL_LIMIT)) begin
              // Gives up rather than hanging on a device that never settles
              flash_ce_n  <= 1'b1;
              rsp_data    <= poll_data;
              rsp_timeout <= 1'b1;
              rsp_valid   <= 1'b1;
              state       <= ST_IDLE;
            end else begin
              flash_oe_n <= 1'b0;
              tmr_load   <= 1'b1;
              tmr_value  <= TIMER_W'(CYC_READ_CYCLE);
              state      <= ST_POLL_ACT;
            end
          end
        end
        ST_UNP_SETUP: begin
          if (!tmr_busy) begin
            in_unprotect <= 1'b1;
            rsp_valid    <= 1'b1;
            state        <= ST_IDLE;
          end
        end
        ST_UNP_WAIT: begin
          // The hold time only starts once the device reports ready
          if (ready_busy_n) begin
            tmr_load  <= 1'b1;
            tmr_value <= TIMER_W'(CYC_UNPROTECT_HOLD);
            state     <= ST_UNP_HOLD;
          end
        end
        ST_UNP_HOLD: begin
          if (!ready_busy_n) begin
            state <= ST_UNP_WAIT;
          end else if (!tmr_busy) begin
            unprotect_high_voltage <= 1'b0;
            in_unprotect           <= 1'b0;
            rsp_valid              <= 1'b1;
            state                  <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Toggle history
  // ---------------------------------------------------------------------------
  // Remembers the toggle bit of the read before the latest one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      older_toggle <= 1'b0;
    end else if (state == ST_POLL_ACT && !tmr_busy) begin
      older_toggle <= prev_toggle;
    end
  end

  assign last_equal = (older_toggle == prev_toggle);

endmodule
`default_nettype wire

// >>> flash_host_ctrl_sva.sv
// Purpose : Concurrent checks on the pins of the flash host controller
// Assumes : One clock domain; long waits are measured by saturating run counters
// Notes   : Counters stop at 1023 so they never wrap during a stuck pin
`timescale 1ns/10ps
`default_nettype none
module flash_host_ctrl_sva
  import flash_host_pkg::*;
#(
  parameter int ADDR_W = 21
) (
  // Clock and reset
  input wire logic                     clk,
  input wire logic                     reset_n,
  // User side
  input wire logic                     cmd_valid,
  input wire flash_host_pkg::host_op_e cmd_op,
  input wire logic                     cmd_ready,
  input wire logic                     rsp_valid,
  // Flash side
  input wire logic                     flash_ce_n,
  input wire logic                     flash_oe_n,
  input wire logic                     flash_we_n,
  input wire logic [ADDR_W-1:0]        flash_addr,
  input wire logic                     flash_dq_oe_n,
  input wire logic                     flash_reset_n,
  input wire logic                     unprotect_high_voltage,
  input wire logic                     ready_busy_n
);
  int hv_cnt;
  int rb_cnt;
  int lo_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Run lengths of elevated reset pin, device ready and reset pin low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hv_cnt <= 0;
      rb_cnt <= 0;
      lo_cnt <= 0;
    end else begin
      hv_cnt <= !unprotect_high_voltage ? 0 : (hv_cnt < 1023) ? hv_cnt + 1 : hv_cnt;
      rb_cnt <= !ready_busy_n ? 0 : (rb_cnt < 1023) ? rb_cnt + 1 : rb_cnt;
      lo_cnt <= flash_reset_n ? 0 : (lo_cnt < 1023) ? lo_cnt + 1 : lo_cnt;
    end
  end
  rst_recover_a: assert property ($rose(flash_reset_n) |-> flash_oe_n [*5])
    else $error("read begun too soon after reset pin release");
  rst_pulse_a: assert property ($rose(flash_reset_n) |-> lo_cnt >= 50)
    else $error("reset pin pulse too short");
  unp_setup_a: assert property (!flash_we_n && unprotect_high_voltage |-> hv_cnt >= 400)
    else $error("write too soon after elevated reset");
  unp_hold_a: assert property ($fell(unprotect_high_voltage) |-> rb_cnt >= 400)
    else $error("elevated reset dropped too soon after ready");
  read_walk_a: assert property (cmd_valid && cmd_ready && cmd_op == OP_READ |=>
    (!flash_ce_n && !flash_oe_n) [*8] ##[1:6] (rsp_valid && flash_ce_n && flash_oe_n))
    else $error("read strobes or answer out of place");
  poll_gap_a: assert property ($rose(flash_oe_n) && !flash_ce_n |=> flash_oe_n)
    else $error("output enable high time too short between polls");
  poll_addr_a: assert property (!flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr))
    else $error("address moved while chip enabled");
  write_pulse_a: assert property ($fell(flash_we_n) |->
    (!flash_we_n && !flash_dq_oe_n && flash_oe_n) [*4])
    else $error("write pulse short or bus contended");
  take_once_a: assert property (cmd_valid && cmd_ready |=> !cmd_ready [*2])
    else $error("second command accepted while busy");
endmodule
bind flash_host_ctrl flash_host_ctrl_sva #(.ADDR_W(ADDR_W)) i_sva (
  .clk, .reset_n, .cmd_valid, .cmd_op, .cmd_ready, .rsp_valid, .flash_ce_n, .flash_oe_n,
  .flash_we_n, .flash_addr, .flash_dq_oe_n, .flash_reset_n, .unprotect_high_voltage, .ready_busy_n
);
`default_nettype wire

// >>> flash_device_model.sv
// Purpose : Behavioural flash array with status reads, reset abort and suspend
// Assumes : Pins sampled on clk; 16 words of storage indexed by low address bits
// Notes   : A released bus shows the inverse of its last value, never a stale copy
`timescale 1ns/10ps
`default_nettype none
module flash_device_model #(
  parameter int         BUSY_CYC = 30,
  parameter logic [4:0] SUSP_SEC = 5'h05
) (
  // Clock
  input  wire logic        clk,
  // Host pins
  input  wire logic        flash_ce_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_we_n,
  input  wire logic [20:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_reset_n,
  // Scenario control and device outputs
  input  wire logic        susp_on,
  input  wire logic        hold_busy,
  output logic      [15:0] flash_dq_in,
  output logic             ready_busy_n
);
  logic [15:0] mem [16];
  logic [15:0] pdata = 16'h0000;
  logic [15:0] last  = 16'h0000;
  logic [15:0] st;
  logic        ce_q  = 1'b1;
  logic        oe_q  = 1'b1;
  logic        we_q  = 1'b1;
  logic        tog   = 1'b0;
  logic        es    = 1'b0;
  logic        stat;
  int          busy  = 0;
  int          lo    = 0;
  // Status word: complemented poll bit, toggle bits
  always_comb begin
    st = pdata;
    st[7] = ~pdata[7];
    st[6] = tog;
    st[2] = es;
  end
  assign stat = (busy > 0) || (susp_on && flash_addr[20:16] == SUSP_SEC);
  assign ready_busy_n = (busy == 0);
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n && flash_reset_n) ?
                       (stat ? st : mem[flash_addr[3:0]]) : ~last;
  // Program, abort and toggle state
  always_ff @(posedge clk) begin
    ce_q <= flash_ce_n;
    oe_q <= flash_oe_n;
    we_q <= flash_we_n;
    // Only driven data is remembered, so a released bus reads as its inverse
    if (!flash_ce_n && !flash_oe_n && flash_reset_n) begin
      last <= flash_dq_in;
    end
    lo <= flash_reset_n ? 0 : lo + 1; // standby once low 2000 cycles; no pin shows it
    if (!flash_reset_n) begin
      busy <= 0;
    end else if (!we_q && flash_we_n && !ce_q) begin
      mem[flash_addr[3:0]] <= flash_dq_out;
      pdata <= flash_dq_out;
      busy <= BUSY_CYC;
    end else if (busy > 0 && !hold_busy) begin
      // hold_busy stands for an algorithm that never finishes
      busy <= busy - 1;
    end
    // Either strobe opens a new status read
    if ((oe_q && !flash_oe_n) || (ce_q && !flash_ce_n)) begin
      if (busy > 0) begin
        tog <= ~tog;
      end
      if (susp_on && flash_addr[20:16] == SUSP_SEC) begin
        es <= ~es;
      end
    end
  end
endmodule
`default_nettype wire

// >>> flash_host_ctrl_bench.sv
// Purpose : Self-checking bench for the flash host controller
// Assumes : Device model programs for 30 cycles; inputs change 1 ns after the edge
// Notes   : Row table for plain traffic, then suspend, reset, stuck poll and unprotect cases
`timescale 1ns/10ps
`default_nettype none
module flash_host_ctrl_bench;
  import flash_host_pkg::*;
  typedef struct {
    host_op_e    op;
    logic [20:0] addr;
    logic [15:0] data, exp, mask;
  } row_s;
  logic        clk       = 1'b0;
  logic        reset_n   = 1'b0;
  logic        cmd_valid = 1'b0;
  host_op_e    cmd_op    = OP_READ;
  logic [20:0] cmd_addr  = 21'h000000;
  logic [15:0] cmd_data  = 16'h0000;
  logic        susp_on   = 1'b0;
  logic        hold_busy = 1'b0;
  logic        rsp_timeout, flash_width_select;
  logic        cmd_ready, rsp_valid, in_unprotect, flash_ce_n, flash_oe_n, flash_we_n;
  logic        flash_dq_oe_n, flash_reset_n, unprotect_high_voltage, ready_busy_n;
  logic [20:0] flash_addr;
  logic [15:0] rsp_data, flash_dq_out, flash_dq_in, s1;
  int          fail_count = 0, comparisons = 0, cycles = 0, n;
  // Write, poll at a far address, read back, read while busy
  row_s rows [6] = '{
    '{OP_WRITE, 21'h000001, 16'h1234, 16'h0000, 16'hFFFF},
    '{OP_POLL,  21'h0A0001, 16'h0000, 16'h1234, 16'hFFFF},
    '{OP_READ,  21'h000001, 16'h0000, 16'h1234, 16'hFFFF},
    '{OP_WRITE, 21'h000002, 16'h5A5A, 16'h1234, 16'hFFFF},
    '{OP_READ,  21'h000002, 16'h0000, 16'h0080, 16'h0080},
    '{OP_POLL,  21'h000002, 16'h0000, 16'h5A5A, 16'hFFFF}};
  // Small poll limit so that a stuck device times out well inside the run
  flash_host_ctrl #(.POLL_LIMIT(8)) i_dut (
    .clk, .reset_n, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .cmd_ready, .rsp_valid, .rsp_data,
    .rsp_timeout, .in_unprotect, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr,
    .flash_dq_out, .flash_dq_oe_n, .flash_dq_in, .flash_reset_n, .unprotect_high_voltage,
    .flash_width_select, .ready_busy_n);
  flash_device_model i_dev (
    .clk, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr, .flash_dq_out, .flash_reset_n,
    .susp_on, .hold_busy, .flash_dq_in, .ready_busy_n);
  always #5 clk = ~clk;
  // Watchdog: the whole run needs some 3250 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("unexpected at %0t: run hung", $time);
      conclude();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One command; n counts cycles from acceptance to answer
  task automatic run(input host_op_e op, input logic [20:0] a, input logic [15:0] d,
                     output int n);
    n = 0;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1;
    reset_n = 1'b1;
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].addr, rows[i].data, n);
      chk(rsp_data & rows[i].mask, rows[i].exp & rows[i].mask);
    end
    chk({15'h0000, rsp_timeout}, 16'h0000);
    // Suspended sector: bit 2 must differ between two reads
    susp_on = 1'b1;
    run(OP_READ, 21'h050003, 16'h0000, n);
    s1 = rsp_data;
    run(OP_READ, 21'h050003, 16'h0000, n);
    chk({15'h0000, s1[2] ^ rsp_data[2]}, 16'h0001);
    susp_on = 1'b0;
    // Idle reset is short, busy reset long and aborts the program
    run(OP_RESET, 21'h000000, 16'h0000, n);
    chk(16'(n >= CYC_RESET_IDLE + CYC_RESET_RECOVER && n < CYC_RESET_BUSY), 16'h0001);
    // A stuck algorithm keeps the toggle bit moving, so the poll must give up
    hold_busy = 1'b1;
    run(OP_WRITE, 21'h000003, 16'hC3C3, n);
    chk({15'h0000, ready_busy_n}, 16'h0000);
    run(OP_POLL, 21'h000003, 16'h0000, n);
    chk({15'h0000, rsp_timeout}, 16'h0001);
    chk(rsp_data & 16'h0080, 16'h0000);
    hold_busy = 1'b0;
    run(OP_RESET, 21'h000000, 16'h0000, n);
    chk({15'h0000, n >= CYC_RESET_BUSY}, 16'h0001);
    chk({15'h0000, ready_busy_n}, 16'h0001);
    // Unprotected write, then exit waits for ready plus hold
    run(OP_UNPROTECT_ENTER, 21'h000000, 16'h0000, n);
    chk({15'h0000, in_unprotect}, 16'h0001);
    run(OP_WRITE, 21'h000004, 16'h0F0F, n);
    run(OP_UNPROTECT_EXIT, 21'h000000, 16'h0000, n);
    chk({15'h0000, n >= CYC_UNPROTECT_HOLD}, 16'h0001);
    chk({15'h0000, in_unprotect}, 16'h0000);
    // Second reset mid-run, then traffic resumes
    reset_n = 1'b0;
    @(posedge clk);
    #1;
    chk({14'h0000, cmd_ready, flash_width_select}, 16'h0000);
    reset_n = 1'b1;
    run(OP_READ, 21'h000004, 16'h0000, n);
    chk(rsp_data, 16'h0F0F);
    chk({15'h0000, flash_width_select}, 16'h0001);
    conclude();
  end
endmodule
`default_nettype wire
